// *** comparator_output_router_pkg.sv ***
// Constants for the comparator control and pin output routing block
package comparator_output_router_pkg;

  // ****************************************
  // Register addresses in the SFR space
  // ****************************************
  localparam logic [15:0] PORT_INPUT_SELECT_CTRL_ADDR = 16'hfe5f;
  localparam logic [15:0] COMPARATOR_CTRL_ADDR = 16'hfecc;

  // ****************************************
  // Comparator control field positions
  // ****************************************
  localparam int MEAS_TRIG_SRC_SEL_BIT = 7;
  localparam int EXT_INT_SRC_SEL_BIT = 6;
  localparam int TEST_BIT_POS = 5;
  localparam int PIN_OUT_SEL_HI_BIT = 4;
  localparam int COMPARATOR_ENABLE_BIT = 3;
  localparam int COMPARATOR_RESULT_BIT = 2;
  localparam int PIN_OUT_SEL_LO_BIT = 1;
  localparam int COMPARATOR_INVERT_BIT = 0;

  // ****************************************
  // Input select control field positions
  // ****************************************
  localparam int PIN_OUT_INVERT_BIT = 3;
  // Bits 5 and 4 do not exist and read as one
  localparam logic [7:0] PISC_ABSENT_MASK = 8'h30;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] COMPARATOR_CTRL_RESET = 8'h00;
  localparam logic [7:0] PORT_INPUT_SELECT_CTRL_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // ****************************************
  // Pin output selector codes
  // ****************************************
  typedef enum logic [1:0] {
    PIN_SEL_OFF = 2'h0,
    PIN_SEL_COMPARATOR = 2'h1,
    PIN_SEL_FILTERED = 2'h2,
    PIN_SEL_MEAS_TRIG = 2'h3
  } pin_sel_e;

  localparam int SYNC_STAGES_DEFAULT = 2;

endpackage

// *** comparator_output_router.sv ***
// Control registers and signal routing around the analog comparator
//
// Notes on behaviour
// - The raw comparator input is high when the positive input exceeds the negative one.
// - The invert bit passes the comparator result when 0 and inverts it when 1.
// - The interrupt source bit routes the pin input when 0 and the comparator when 1.
// - Selector bits 4 and 1 pick off, comparator, filtered interrupt or trigger.
// - With selector code 00 the selector output is a constant low.
// - The pin invert bit passes the selector output when 0 and inverts it when 1.
// - The possibly inverted selector signal is ORed with the port latch bit for the pin.
// - The enable bit stops the comparator when 0 and runs it when 1.
// - An enabled comparator keeps running through halt and hold standby.
// - The result bit is read-only, reads the current comparator output, ignores writes.
// - The comparator output is offered as a trigger to counter two, chosen by bit 7.
// - Through the interrupt path the comparator gets the noise filter and hold release.
`timescale 1ns/100ps
module comparator_output_router
  import comparator_output_router_pkg::*;
#(
  parameter int SYNC_STAGES = comparator_output_router_pkg::SYNC_STAGES_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // SFR access
  input wire logic [15:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  // Analog comparator
  input wire logic comparatorRaw,
  output logic comparatorEnable,
  // Shared pin and port
  input wire logic pinIn,
  input wire logic port3Bit2Latch,
  output logic pinOut,
  // External interrupt circuit
  input wire logic extIntFiltered,
  output logic extIntSource,
  // Measurement counter two
  input wire logic measTrigger,
  output logic measTrigSrcSel,
  output logic measComparatorOut
);
  import comparator_output_router_pkg::*;

  // Fewer than two stages would pass a metastable level straight on
  if (SYNC_STAGES < 2) begin : gBadStages
    $error("SYNC_STAGES must be at least 2");
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] compCtrl_q;
  logic [7:0] compCtrl_d;
  logic [7:0] portSel_q;
  logic [7:0] portSel_d;
  logic [SYNC_STAGES-1:0] sync_q;
  logic [7:0] rdData_q;
  logic [7:0] rdData_d;
  logic pinOut_q;
  logic extIntSource_q;
  logic measComparatorOut_q;

  wire compWrite = sfrWrEn && (sfrAddr == COMPARATOR_CTRL_ADDR);
  wire portWrite = sfrWrEn && (sfrAddr == PORT_INPUT_SELECT_CTRL_ADDR);

  // Result bit holds no storage; writes to it are dropped
  wire [7:0] resultMask = 8'h01 << COMPARATOR_RESULT_BIT;
  assign compCtrl_d = compWrite ? (sfrWrData & ~resultMask) : compCtrl_q;
  assign portSel_d = portWrite ? (sfrWrData & ~PISC_ABSENT_MASK) : portSel_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      compCtrl_q <= COMPARATOR_CTRL_RESET;
      portSel_q <= PORT_INPUT_SELECT_CTRL_RESET;
    end else begin
      compCtrl_q <= compCtrl_d;
      portSel_q <= portSel_d;
    end
  end

  // ****************************************
  // Comparator path
  // ****************************************
  wire enableBit = compCtrl_q[COMPARATOR_ENABLE_BIT];
  wire invertBit = compCtrl_q[COMPARATOR_INVERT_BIT];
  wire extSelBit = compCtrl_q[EXT_INT_SRC_SEL_BIT];
  wire pinInvBit = portSel_q[PIN_OUT_INVERT_BIT];
  wire [1:0] pinSel = {compCtrl_q[PIN_OUT_SEL_HI_BIT], compCtrl_q[PIN_OUT_SEL_LO_BIT]};

  // No standby input exists here, so halt or hold cannot stop it
  assign comparatorEnable = enableBit;

  // Stopped comparator reads as a low raw level
  wire rawGated = comparatorRaw && enableBit;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[SYNC_STAGES-2:0], rawGated};
    end
  end

  wire compOut = sync_q[SYNC_STAGES-1] ^ invertBit;

  // ****************************************
  // Routing
  // ****************************************
  // The interrupt circuit applies its own filter and hold release to this
  wire extIntSrc_d = extSelBit ? compOut : pinIn;

  // Pin input as interrupt source with code 10 would loop the pin onto itself
  logic selOut;
  always_comb begin
    case (pin_sel_e'(pinSel))
      PIN_SEL_OFF: selOut = 1'b0;
      PIN_SEL_COMPARATOR: selOut = compOut;
      PIN_SEL_FILTERED: selOut = extIntFiltered;
      PIN_SEL_MEAS_TRIG: selOut = measTrigger;
      default: selOut = 1'b0;
    endcase
  end

  // Latch bit must be 0 for the routed signal to show; see the OR below
  wire pinOut_d = (selOut ^ pinInvBit) | port3Bit2Latch;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinOut_q <= 1'b0;
      extIntSource_q <= 1'b0;
      measComparatorOut_q <= 1'b0;
    end else begin
      pinOut_q <= pinOut_d;
      extIntSource_q <= extIntSrc_d;
      measComparatorOut_q <= compOut;
    end
  end

  assign pinOut = pinOut_q;
  assign extIntSource = extIntSource_q;
  assign measComparatorOut = measComparatorOut_q;
  assign measTrigSrcSel = compCtrl_q[MEAS_TRIG_SRC_SEL_BIT];

  // ****************************************
  // Read back
  // ****************************************
  // Result bit shows the live comparator output, used to tell edge direction
  wire [7:0] compRead = compCtrl_q | (compOut ? resultMask : 8'h00);
  wire [7:0] portRead = portSel_q | PISC_ABSENT_MASK;
  wire isComp = (sfrAddr == COMPARATOR_CTRL_ADDR);
  wire isPort = (sfrAddr == PORT_INPUT_SELECT_CTRL_ADDR);
  assign rdData_d = isComp ? compRead : (isPort ? portRead : UNMAPPED_READ_VALUE);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdData_q <= UNMAPPED_READ_VALUE;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign sfrRdData = rdData_q;

  // ****************************************
  // Assertions
  // ****************************************
  AST_RAW_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
    (comparatorRaw && enableBit && !invertBit && !compWrite)[*3] |-> compOut)
    else $error("comparator output not high after raw high");

  AST_INVERT: assert property (@(posedge clk) disable iff (sys_rst)
    (comparatorRaw && enableBit && invertBit && !compWrite)[*3] |-> !compOut)
    else $error("inverted comparator output not low");

  AST_STOPPED: assert property (@(posedge clk) disable iff (sys_rst)
    (!enableBit && !compWrite)[*3] |-> (compOut == invertBit))
    else $error("stopped comparator still shows a result");

  AST_SYNC_DELAY: assert property (@(posedge clk) disable iff (sys_rst)
    (enableBit && !compWrite)[*3] |-> (sync_q[SYNC_STAGES-1] == $past(comparatorRaw, 2)))
    else $error("synchroniser delay wrong");

  AST_EXT_SOURCE: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> (extIntSource == ($past(extSelBit) ? $past(compOut) : $past(pinIn))))
    else $error("interrupt source routed wrong");

  AST_PIN_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    (pinSel == 2'h0 && !pinInvBit && !port3Bit2Latch) |=> !pinOut)
    else $error("pin not low with selector off");

  AST_PIN_ROUTE: assert property (@(posedge clk) disable iff (sys_rst)
    (pinSel == 2'h2) |=> (pinOut == (($past(extIntFiltered) ^ $past(pinInvBit))
      | $past(port3Bit2Latch))))
    else $error("filtered signal not on pin");

  AST_PIN_TRIG: assert property (@(posedge clk) disable iff (sys_rst)
    (pinSel == 2'h3 && pinInvBit && !port3Bit2Latch) |=> (pinOut == !$past(measTrigger)))
    else $error("trigger not inverted onto pin");

  AST_PIN_OR: assert property (@(posedge clk) disable iff (sys_rst)
    port3Bit2Latch |=> pinOut)
    else $error("latch bit not ORed onto pin");

  AST_RESULT_READ: assert property (@(posedge clk) disable iff (sys_rst)
    (isComp && !compWrite) |=> (sfrRdData[COMPARATOR_RESULT_BIT] == $past(compOut)))
    else $error("result bit read wrong");

  AST_MEAS_OUT: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> (measComparatorOut == $past(compOut)))
    else $error("counter trigger copy wrong");

  // ****************************************
  // Assertions: comparator levels and timing
  // ****************************************
  AST_RAW_LOW: assert property (@(posedge clk) disable iff (sys_rst)
    (!comparatorRaw && enableBit && !invertBit && !compWrite)[*3] |-> !compOut)
    else $error("comparator output not low after raw low");

  AST_INVERT_LOW_RAW: assert property (@(posedge clk) disable iff (sys_rst)
    (!comparatorRaw && enableBit && invertBit && !compWrite)[*3] |-> compOut)
    else $error("inverted comparator output not high");

  AST_MEAS_FOLLOW: assert property (@(posedge clk) disable iff (sys_rst)
    (comparatorRaw && enableBit && !invertBit && !compWrite)[*4] |-> measComparatorOut)
    else $error("counter trigger not high after raw high");

  AST_MEAS_LOW: assert property (@(posedge clk) disable iff (sys_rst)
    (!comparatorRaw && enableBit && !invertBit && !compWrite)[*4] |-> !measComparatorOut)
    else $error("counter trigger not low after raw low");

  // A raw edge must not reach the output before both stages have seen it
  AST_SYNC_NO_SHORTCUT: assert property (@(posedge clk) disable iff (sys_rst)
    (enableBit && !invertBit && !compWrite)[*2] ##0 $rose(comparatorRaw) |=> !compOut)
    else $error("raw edge reached the output too early");

  // ****************************************
  // Assertions: routing and register access
  // ****************************************
  AST_EXT_PIN: assert property (@(posedge clk) disable iff (sys_rst)
    !extSelBit |=> (extIntSource == $past(pinIn)))
    else $error("pin input not routed to interrupt");

  AST_EXT_COMP: assert property (@(posedge clk) disable iff (sys_rst)
    extSelBit |=> (extIntSource == $past(compOut)))
    else $error("comparator not routed to interrupt");

  AST_PIN_COMP: assert property (@(posedge clk) disable iff (sys_rst)
    (pinSel == 2'h1 && !pinInvBit && !port3Bit2Latch) |=> (pinOut == $past(compOut)))
    else $error("comparator not on pin");

  AST_PIN_TRIG_PLAIN: assert property (@(posedge clk) disable iff (sys_rst)
    (pinSel == 2'h3 && !pinInvBit && !port3Bit2Latch) |=> (pinOut == $past(measTrigger)))
    else $error("trigger not on pin");

  AST_PIN_COMP_INV: assert property (@(posedge clk) disable iff (sys_rst)
    (pinSel == 2'h1 && pinInvBit && !port3Bit2Latch) |=> (pinOut == !$past(compOut)))
    else $error("comparator not inverted onto pin");

  AST_PIN_OFF_INV: assert property (@(posedge clk) disable iff (sys_rst)
    (pinSel == 2'h0 && pinInvBit) |=> pinOut)
    else $error("inverted idle selector not high on pin");

  AST_PIN_NO_LATCH: assert property (@(posedge clk) disable iff (sys_rst)
    (pinSel == 2'h2 && !pinInvBit && !port3Bit2Latch) |=> (pinOut == $past(extIntFiltered)))
    else $error("pin not following selector with latch low");

  AST_PORT_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    portWrite |=> (pinInvBit == $past(sfrWrData[PIN_OUT_INVERT_BIT])))
    else $error("pin invert bit write not applied");

  AST_ENABLE_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    compWrite |=> (comparatorEnable == $past(sfrWrData[COMPARATOR_ENABLE_BIT])))
    else $error("enable bit write not applied");

  // Reset must leave the comparator stopped and every routed output low
  AST_RESET_STOP: assert property (@(posedge clk)
    sys_rst |=> (!comparatorEnable && !pinOut && !extIntSource && !measComparatorOut))
    else $error("reset did not stop the comparator");

  AST_COMP_WRITE_LAND: assert property (@(posedge clk) disable iff (sys_rst)
    compWrite |=> (compCtrl_q == ($past(sfrWrData) & ~resultMask)))
    else $error("control write stored wrong");

  AST_RESULT_NO_STORE: assert property (@(posedge clk) disable iff (sys_rst)
    (isComp && compWrite) |=> (sfrRdData[COMPARATOR_RESULT_BIT] == $past(compOut)))
    else $error("result bit took a written value");

  AST_TRIG_SEL_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    compWrite |=> (measTrigSrcSel == $past(sfrWrData[MEAS_TRIG_SRC_SEL_BIT])))
    else $error("trigger source bit write not applied");

  COV_COMP_ON_PIN: cover property (@(posedge clk) disable iff (sys_rst)
    (pinSel == 2'h1) && compOut ##1 pinOut);
  COV_COMP_INT: cover property (@(posedge clk) disable iff (sys_rst)
    extSelBit && $rose(compOut));
  COV_READ_RESULT: cover property (@(posedge clk) disable iff (sys_rst)
    isComp ##1 sfrRdData[COMPARATOR_RESULT_BIT]);
  COV_INVERTED: cover property (@(posedge clk) disable iff (sys_rst)
    enableBit && invertBit && comparatorRaw ##3 !compOut);
  COV_WRITE_READ: cover property (@(posedge clk) disable iff (sys_rst)
    compWrite ##1 isComp);

endmodule

// *** comparator_pin_model.sv ***
// Behavioural analog comparator standing behind the routing block
`timescale 1ns/100ps
module comparator_pin_model (
  // Clock
  input wire logic clk,
  // Control and analog levels in millivolts
  input wire logic comparatorEnable,
  input wire logic [11:0] posMv,
  input wire logic [11:0] negMv,
  // Digital result
  output logic comparatorRaw
);
  logic stopPat = 1'b0;

  // A stopped comparator gives no trustworthy level, so it wanders
  always @(posedge clk) stopPat <= ~stopPat;
  // Keeps comparing whatever the standby state is
  assign comparatorRaw = comparatorEnable ? (posMv > negMv) : stopPat;
endmodule

// *** comparator_output_router_test.sv ***
// Self-checking bench for the comparator routing block
`timescale 1ns/100ps
module comparator_output_router_test;
  import comparator_output_router_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] sfrAddr = 16'h0000;
  logic sfrWrEn = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic [7:0] sfrRdData;
  logic comparatorRaw, comparatorEnable, pinOut, extIntSource, measTrigSrcSel;
  logic pinIn = 1'b0;
  logic port3Bit2Latch = 1'b0;
  logic extIntFiltered = 1'b0;
  logic measTrigger = 1'b0;
  logic measComparatorOut;
  logic [11:0] posMv = 12'h100;
  logic [11:0] negMv = 12'h200;
  int error_cnt = 0;
  int tests_run = 0;
  int cmpReg, piscReg, compOut, sel, pinExp, en, intExp;
  int rawQ[$];

  always #12.5 clk = ~clk;

  comparator_output_router i_dut (.clk(clk), .sys_rst(sys_rst), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
    .comparatorRaw(comparatorRaw), .comparatorEnable(comparatorEnable), .pinIn(pinIn),
    .port3Bit2Latch(port3Bit2Latch), .pinOut(pinOut), .extIntFiltered(extIntFiltered),
    .extIntSource(extIntSource), .measTrigger(measTrigger),
    .measTrigSrcSel(measTrigSrcSel), .measComparatorOut(measComparatorOut));

  comparator_pin_model i_model (.clk(clk), .comparatorEnable(comparatorEnable),
    .posMv(posMv), .negMv(negMv), .comparatorRaw(comparatorRaw));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    @(negedge clk);
    sfrWrEn = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(negedge clk);
    sfrAddr = a;
    @(negedge clk);
    chk(what, exp, sfrRdData);
  endtask

  // Reference model works on integers only, then compares every output
  task automatic checkAll();
    repeat (5) @(negedge clk);
    en = (cmpReg >> 3) & 1;
    compOut = en ? (int'(posMv > negMv) ^ (cmpReg & 1)) : (cmpReg & 1);
    sel = ((cmpReg >> 3) & 2) | ((cmpReg >> 1) & 1);
    pinExp = (sel == 1) ? compOut : (sel == 2) ? extIntFiltered : (sel == 3) ? measTrigger : 0;
    pinExp = (pinExp ^ ((piscReg >> 3) & 1)) | port3Bit2Latch;
    chk("pinOut", 8'(pinExp), {7'h00, pinOut});
    intExp = ((cmpReg >> 6) & 1) ? compOut : pinIn;
    chk("extIntSource", 8'(intExp), {7'h00, extIntSource});
    chk("measComparatorOut", 8'(compOut), {7'h00, measComparatorOut});
    chk("measTrigSrcSel", 8'((cmpReg >> 7) & 1), {7'h00, measTrigSrcSel});
    chk("comparatorEnable", 8'(en), {7'h00, comparatorEnable});
    rd(COMPARATOR_CTRL_ADDR, 8'((cmpReg & 'hfb) | (compOut << 2)), "comparator_ctrl");
    rd(PORT_INPUT_SELECT_CTRL_ADDR, 8'(piscReg | 'h30), "port_input_select_ctrl");
    rd(16'hfecd, 8'h00, "unmapped");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32));
    cmpReg = 0;
    piscReg = 0;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    checkAll();
    $display("test reset values done");
    // Raw edge must take exactly three edges to reach the pin
    cmpReg = 'h0a;
    wr(COMPARATOR_CTRL_ADDR, 8'h0a);
    checkAll();
    // Queue holds the raw level of each edge; the pin shows it three edges on
    negMv = 12'h050;
    rawQ = '{0, 0};
    for (int e = 0; e < 8; e++) begin
      if (e == 4) begin
        negMv = 12'h200;
      end
      rawQ.push_back(int'(posMv > negMv));
      @(negedge clk);
      chk("pinOut through sync", 8'(rawQ.pop_front()), {7'h00, pinOut});
    end
    $display("test synchroniser latency done");
    // Edge direction comes from the result bit once the interrupt input moves
    cmpReg = 'h48;
    wr(COMPARATOR_CTRL_ADDR, 8'h48);
    checkAll();
    for (int e = 0; e < 2; e++) begin
      negMv = e ? 12'h200 : 12'h050;
      repeat (3) @(negedge clk);
      chk("extIntSource edge", 8'(1 - e), {7'h00, extIntSource});
      rd(COMPARATOR_CTRL_ADDR, 8'h48 | 8'((1 - e) << 2), "result after edge");
    end
    $display("test edge direction done");
    for (int i = 0; i < 40; i++) begin
      cmpReg = $urandom & 'hdf;
      if (((cmpReg >> 6) & 1) == 0 && (cmpReg & 'h12) == 'h10) cmpReg |= 'h40;
      piscReg = $urandom & 'hcf;
      wr(COMPARATOR_CTRL_ADDR, 8'(cmpReg));
      wr(PORT_INPUT_SELECT_CTRL_ADDR, 8'(piscReg));
      posMv = 12'($urandom);
      negMv = posMv + 12'($urandom_range(1, 4000));
      pinIn = 1'($urandom);
      port3Bit2Latch = 1'($urandom);
      extIntFiltered = 1'($urandom);
      measTrigger = 1'($urandom);
      checkAll();
    end
    $display("test random routing done");
    report_and_stop();
  end

  // Whole run needs well under two thousand cycles
  initial begin
    #50000;
    error_cnt++;
    report_and_stop();
  end
endmodule
